// File: src/sccmd_map.vh
`ifndef SCCMD_MAP_VH
`define SCCMD_MAP_VH
// command codes from the host
`define SCCMD_OP_AUTH      8'h90
`define SCCMD_OP_AUTH1     8'h8e
`define SCCMD_OP_AUTH2     8'h8f
`define SCCMD_OP_SELECT    8'h98
`define SCCMD_OP_FORMAT    8'h99
`define SCCMD_OP_CREATE    8'h95
`define SCCMD_OP_CHGSET    8'h91
`define SCCMD_OP_GETSET    8'h92
// failure codes
`define SCCMD_FAIL_AUTH    8'h6f
`define SCCMD_FAIL_AUTH1   8'h71
`define SCCMD_FAIL_AUTH2   8'h70
`define SCCMD_FAIL_SELECT  8'h67
`define SCCMD_FAIL_FORMAT  8'h67
`define SCCMD_FAIL_CREATE  8'h6a
`define SCCMD_FAIL_CHGSET  8'h6e
`define SCCMD_FAIL_GETSET  8'h6d
`define SCCMD_FAIL_UNKNOWN 8'hff
// card status codes relayed
`define SCCMD_ST_OK            8'h90
`define SCCMD_ST_AUTH_ERR      8'h06
`define SCCMD_ST_OVERFLOW      8'h07
`define SCCMD_ST_BAD_TAG       8'h08
`define SCCMD_ST_BAD_BLOCK     8'h09
`define SCCMD_ST_NO_BLOCK      8'h0a
`define SCCMD_ST_COND_UNMET    8'h0b
`define SCCMD_ST_LEN_ERR       8'h0c
`define SCCMD_ST_INTERNAL      8'h0f
`define SCCMD_ST_MORE          8'haf
// parameter lengths
`define SCCMD_LEN_AUTH     6'd17
`define SCCMD_LEN_AUTH1    6'd1
`define SCCMD_LEN_AUTH2    6'd16
`define SCCMD_LEN_AID      6'd3
`define SCCMD_LEN_NONE     6'd0
`define SCCMD_LEN_CREATE   6'd5
`define SCCMD_LEN_CHGSET   6'd8
// reply payload lengths
`define SCCMD_RLEN_SECRET  6'd16
`define SCCMD_RLEN_NONCE   6'd8
`define SCCMD_RLEN_GETSET  6'd2
`define SCCMD_BUF_DEPTH    32
`endif

// File: src/sccmd_status_class.v
`timescale 1ns/1ps
// classifies a relayed card status byte into its known meaning
module sccmd_status_class (
   // status in
   input wire [7:0] i_status,
   // class out
   output reg o_known,
   output reg o_ok
);
`include "sccmd_map.vh"

always @* begin
   o_ok = (i_status == `SCCMD_ST_OK);
   case (i_status)
      `SCCMD_ST_OK, `SCCMD_ST_AUTH_ERR, `SCCMD_ST_INTERNAL: o_known = 1'b1;
      `SCCMD_ST_BAD_BLOCK, `SCCMD_ST_NO_BLOCK: o_known = 1'b1;
      `SCCMD_ST_OVERFLOW, `SCCMD_ST_BAD_TAG: o_known = 1'b1;
      `SCCMD_ST_COND_UNMET, `SCCMD_ST_LEN_ERR, `SCCMD_ST_MORE: o_known = 1'b1;
      default: o_known = 1'b0;
   endcase
end

endmodule

// File: src/sccmd_handler.v
// Function
// - relay card status byte: 0x90 ok, 0x06 auth/block, 0x0F internal
// - relay 0x09 illegal block, 0x0A missing block unchanged
// - relay 0x07 overflow, 0x08 bad tag, 0x0B unmet, 0x0C length
// - success reply carries card status even when card refused
// - 0x90 takes key index plus 16-byte key; failure code 0x6F
// - one-shot reply appends 16-byte session secret only on success
// - 0x8E takes key index; returns status plus 8-byte nonce, else 0x71
// - 0x8F carries host ciphertext; returns status and reply, else 0x70
// - 0x98 selects three-byte application, lsb first; failure 0x67
// - 0x99 formats card deleting all; failure 0x67
// - 0x95 creates application with id, key config, count; failure 0x6A
// - 0x91 carries 8-byte encrypted key settings; failure 0x6E
// - change key settings uses des cipher and crc on card path
// - 0x92 returns status, key config byte, highest key count; failure 0x6D
// - des used for auth; rf encryption follows user setting
`timescale 1ns/1ps
module sccmd_handler (
   // clock and reset
   input wire i_clk,
   input wire i_resetn,
   // host command bytes, framing and checksum already stripped
   input wire i_cmd_valid,
   input wire [7:0] i_cmd_data,
   input wire i_cmd_last,
   output wire o_cmd_ready,
   // user setting for rf encryption
   input wire i_rf_encrypt,
   // card exchange request
   output reg o_card_req,
   output reg [7:0] o_card_op,
   output reg o_card_des,
   output reg o_card_crc,
   output reg o_card_encrypt,
   output reg [5:0] o_card_len,
   output reg [7:0] o_card_tx_data,
   input wire [4:0] i_card_tx_idx,
   // card exchange answer
   input wire i_card_done,
   input wire i_card_ok,
   input wire [7:0] i_card_status,
   input wire i_card_rx_valid,
   input wire [7:0] i_card_rx_data,
   // reply bytes toward host framer
   output wire o_rsp_valid,
   output reg [7:0] o_rsp_data,
   output wire o_rsp_last,
   input wire i_rsp_ready,
   // status
   output reg o_auth_pending,
   output reg o_status_known
);
`include "sccmd_map.vh"

// =====================================
// states
localparam ST_RECV = 3'd0;
localparam ST_CHECK = 3'd1;
localparam ST_CARD = 3'd2;
localparam ST_WAIT = 3'd3;
localparam ST_REPLY = 3'd4;

// =====================================
// registers
reg [2:0] state_q;
reg [7:0] op_q;
reg [5:0] cnt_q;
reg [5:0] rlen_q;
reg [5:0] ridx_q;
reg [7:0] buf_q [0:`SCCMD_BUF_DEPTH-1];
reg [7:0] rbuf_q [0:`SCCMD_BUF_DEPTH-1];
reg [5:0] rxcnt_q;
reg fail_q;
reg [7:0] status_q;
reg more_q;

reg [5:0] exp_len;
reg [7:0] fail_code;
reg [5:0] pay_len;
reg known_op;
wire st_known;
wire st_ok;
integer i;

// =====================================
// status classifier
// classified at done so the flag matches the relayed byte
sccmd_status_class u_class (
   .i_status(i_card_status),
   .o_known(st_known),
   .o_ok(st_ok)
);

// =====================================
// per-command layout
always @* begin
   exp_len = `SCCMD_LEN_NONE;
   fail_code = `SCCMD_FAIL_UNKNOWN;
   pay_len = 6'd0;
   known_op = 1'b1;
   case (op_q)
      `SCCMD_OP_AUTH: begin
         exp_len = `SCCMD_LEN_AUTH;
         fail_code = `SCCMD_FAIL_AUTH;
         pay_len = `SCCMD_RLEN_SECRET;
      end
      `SCCMD_OP_AUTH1: begin
         exp_len = `SCCMD_LEN_AUTH1;
         fail_code = `SCCMD_FAIL_AUTH1;
         pay_len = `SCCMD_RLEN_NONCE;
      end
      `SCCMD_OP_AUTH2: begin
         exp_len = `SCCMD_LEN_AUTH2;
         fail_code = `SCCMD_FAIL_AUTH2;
         pay_len = `SCCMD_RLEN_NONCE;
      end
      `SCCMD_OP_SELECT: begin
         exp_len = `SCCMD_LEN_AID;
         fail_code = `SCCMD_FAIL_SELECT;
      end
      `SCCMD_OP_FORMAT: begin
         exp_len = `SCCMD_LEN_NONE;
         fail_code = `SCCMD_FAIL_FORMAT;
      end
      `SCCMD_OP_CREATE: begin
         exp_len = `SCCMD_LEN_CREATE;
         fail_code = `SCCMD_FAIL_CREATE;
      end
      `SCCMD_OP_CHGSET: begin
         exp_len = `SCCMD_LEN_CHGSET;
         fail_code = `SCCMD_FAIL_CHGSET;
      end
      `SCCMD_OP_GETSET: begin
         exp_len = `SCCMD_LEN_NONE;
         fail_code = `SCCMD_FAIL_GETSET;
         pay_len = `SCCMD_RLEN_GETSET;
      end
      default: known_op = 1'b0;
   endcase
end

// =====================================
// host handshakes
assign o_cmd_ready = (state_q == ST_RECV);
assign o_rsp_valid = (state_q == ST_REPLY);
assign o_rsp_last = (state_q == ST_REPLY) && (ridx_q == rlen_q);

// =====================================
// reply byte 0 is the code, then status, then payload
always @* begin
   o_rsp_data = rbuf_q[ridx_q[4:0] - 5'd2];
   case (ridx_q)
      6'd0: begin
         o_rsp_data = fail_q ? fail_code : op_q;
      end
      6'd1: begin
         o_rsp_data = status_q;
      end
      default: begin
         o_rsp_data = rbuf_q[ridx_q[4:0] - 5'd2];
      end
   endcase
end

// =====================================
// sequencing
always @(posedge i_clk) begin
   if (!i_resetn) begin
      state_q <= ST_RECV;
      op_q <= 8'h00;
      cnt_q <= 6'd0;
      rlen_q <= 6'd0;
      ridx_q <= 6'd0;
      rxcnt_q <= 6'd0;
      fail_q <= 1'b0;
      status_q <= 8'h00;
      more_q <= 1'b0;
      o_card_req <= 1'b0;
      o_card_op <= 8'h00;
      o_card_des <= 1'b0;
      o_card_crc <= 1'b0;
      o_card_encrypt <= 1'b0;
      o_card_len <= 6'd0;
      o_card_tx_data <= 8'h00;
      o_auth_pending <= 1'b0;
      o_status_known <= 1'b0;
      for (i = 0; i < `SCCMD_BUF_DEPTH; i = i + 1) begin
         buf_q[i] <= 8'h00;
         rbuf_q[i] <= 8'h00;
      end
   end else begin
      o_card_req <= 1'b0;
      o_card_tx_data <= buf_q[i_card_tx_idx];
      case (state_q)
         ST_RECV: begin
            if (i_cmd_valid) begin
               if (cnt_q == 6'd0) begin
                  op_q <= i_cmd_data;
               end else if (cnt_q <= 6'd32) begin
                  buf_q[cnt_q[4:0] - 5'd1] <= i_cmd_data;
               end
               // saturate so a long frame cannot wrap to a legal length
               if (cnt_q != 6'd63) begin
                  cnt_q <= cnt_q + 6'd1;
               end
               if (i_cmd_last) begin
                  state_q <= ST_CHECK;
               end
            end
         end
         ST_CHECK: begin
            if (!known_op || (cnt_q - 6'd1) != exp_len) begin
               fail_q <= 1'b1;
               rlen_q <= 6'd0;
               ridx_q <= 6'd0;
               state_q <= ST_REPLY;
            end else begin
               state_q <= ST_CARD;
            end
         end
         ST_CARD: begin
            // request lasts one cycle; qualifiers hold until next command
            o_card_req <= 1'b1;
            o_card_op <= op_q;
            o_card_len <= exp_len;
            o_card_des <= 1'b1;
            o_card_encrypt <= i_rf_encrypt;
            o_card_crc <= (op_q == `SCCMD_OP_CHGSET);
            rxcnt_q <= 6'd0;
            state_q <= ST_WAIT;
         end
         ST_WAIT: begin
            // payload kept in arrival order, excess dropped
            if (i_card_rx_valid && rxcnt_q < 6'd32) begin
               rbuf_q[rxcnt_q[4:0]] <= i_card_rx_data;
               rxcnt_q <= rxcnt_q + 6'd1;
            end
            if (i_card_done) begin
               ridx_q <= 6'd0;
               state_q <= ST_REPLY;
               if (!i_card_ok) begin
                  fail_q <= 1'b1;
                  rlen_q <= 6'd0;
                  more_q <= 1'b0;
               end else begin
                  fail_q <= 1'b0;
                  status_q <= i_card_status;
                  o_status_known <= st_known;
                  if (op_q == `SCCMD_OP_AUTH && !st_ok) begin
                     rlen_q <= 6'd1;
                  end else begin
                     rlen_q <= 6'd1 + pay_len;
                  end
                  more_q <= (op_q == `SCCMD_OP_AUTH1) &&
                            (i_card_status == `SCCMD_ST_MORE);
               end
            end
         end
         ST_REPLY: begin
            if (i_rsp_ready) begin
               if (ridx_q == rlen_q) begin
                  state_q <= ST_RECV;
                  cnt_q <= 6'd0;
                  fail_q <= 1'b0;
                  o_auth_pending <= more_q;
                  more_q <= 1'b0;
               end else begin
                  ridx_q <= ridx_q + 6'd1;
               end
            end
         end
         default: state_q <= ST_RECV;
      endcase
   end
end

endmodule

// File: bench/sccmd_assertions.sv
`timescale 1ns/1ps
// ====================
// handler port checks
module sccmd_checker (
   input wire i_clk,
   input wire i_resetn,
   input wire o_cmd_ready,
   input wire o_card_req,
   input wire [7:0] o_card_op,
   input wire o_card_des,
   input wire o_card_crc,
   input wire i_card_done,
   input wire i_card_ok,
   input wire [7:0] i_card_status,
   input wire o_rsp_valid,
   input wire [7:0] o_rsp_data,
   input wire o_rsp_last,
   input wire i_rsp_ready,
   input wire o_auth_pending,
   input wire o_status_known
);
   wire done_ok = i_card_done && i_card_ok;
   wire rsp_end = o_rsp_valid && o_rsp_last && i_rsp_ready;
   reg exp_pend_q;
   always @(posedge i_clk) begin
      if (!i_resetn)
         exp_pend_q <= 1'b0;
      else if (done_ok)
         exp_pend_q <= (o_card_op == 8'h8e) && (i_card_status == 8'haf);
      else if (i_card_done || rsp_end)
         exp_pend_q <= 1'b0;
   end
   function [7:0] fcode(input [7:0] op);
      case (op)
         8'h90: fcode = 8'h6f;
         8'h8e: fcode = 8'h71;
         8'h8f: fcode = 8'h70;
         8'h98, 8'h99: fcode = 8'h67;
         8'h95: fcode = 8'h6a;
         8'h91: fcode = 8'h6e;
         8'h92: fcode = 8'h6d;
         default: fcode = 8'hff;
      endcase
   endfunction
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   chk_des_req_pulse:
      assert property (o_card_req |-> o_card_des ##1 !o_card_req) else $error("request not a des pulse");
   chk_crc_chgset:
      assert property (o_card_req |-> o_card_crc == (o_card_op == 8'h91)) else $error("crc flag wrong");
   chk_echo_code:
      assert property (done_ok |=> o_rsp_valid && o_rsp_data == o_card_op) else $error("code not echoed");
   chk_fail_code:
      assert property (i_card_done && !i_card_ok |=> o_rsp_valid && o_rsp_last && o_rsp_data == fcode(o_card_op))
         else $error("wrong failure reply");
   chk_status_byte:
      assert property (done_ok ##1 (o_rsp_valid && i_rsp_ready) |=> o_rsp_data == $past(i_card_status, 2))
         else $error("status not relayed");
   chk_auth_pending:
      assert property (rsp_end |=> o_auth_pending == $past(exp_pend_q))
         else $error("pending not set");
   chk_status_known:
      assert property (done_ok |=> o_status_known == ($past(i_card_status) inside
         {8'h90, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0f, 8'haf})) else $error("known flag wrong");
   chk_rsp_hold:
      assert property (o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_data)) else $error("reply dropped");
   chk_busy_refuse:
      assert property (o_rsp_valid |-> !o_cmd_ready) else $error("ready while replying");
   cover property (done_ok && o_card_op == 8'h8e);
   cover property (i_card_done && !i_card_ok);
   cover property (o_rsp_valid && o_rsp_last && o_rsp_data == 8'h67);
endmodule
bind sccmd_handler sccmd_checker u_chk (
   .i_clk(i_clk), .i_resetn(i_resetn), .o_cmd_ready(o_cmd_ready), .o_card_req(o_card_req),
   .o_card_op(o_card_op), .o_card_des(o_card_des), .o_card_crc(o_card_crc), .i_card_done(i_card_done),
   .i_card_ok(i_card_ok), .i_card_status(i_card_status), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
   .o_rsp_last(o_rsp_last), .i_rsp_ready(i_rsp_ready), .o_auth_pending(o_auth_pending),
   .o_status_known(o_status_known)
);

// File: bench/sccmd_card_model.sv
`timescale 1ns/1ps
// ====================
// card side model
module sccmd_card_model (
   input wire i_clk,
   input wire i_req,
   input wire i_ok,
   input wire [7:0] i_status,
   input wire [4:0] i_nrx,
   input wire [3:0] i_wait,
   output reg [4:0] o_tx_idx = 5'h00,
   output reg o_done = 1'b0,
   output reg o_ok = 1'b0,
   output wire [7:0] o_status,
   output reg o_rx_valid = 1'b0,
   output reg [7:0] o_rx_data = 8'h00
);
   reg busy_q = 1'b0;
   reg [5:0] cnt_q = 6'h00;
   wire [5:0] w6 = {2'h0, i_wait};
   wire [5:0] k6 = cnt_q - w6;
   // status only meaningful at done, so it wanders otherwise
   assign o_status = o_done ? i_status : ~i_status;
   always @(posedge i_clk) begin
      o_done <= 1'b0;
      o_ok <= ~o_ok;
      o_rx_valid <= 1'b0;
      o_rx_data <= ~o_rx_data;
      o_tx_idx <= cnt_q[4:0];
      if (i_req) begin
         busy_q <= 1'b1;
         cnt_q <= 6'h00;
      end else if (busy_q) begin
         cnt_q <= cnt_q + 6'h01;
         if (cnt_q >= w6 && k6 < {1'b0, i_nrx}) begin
            o_rx_valid <= 1'b1;
            o_rx_data <= 8'ha0 + {2'h0, k6};
         end
         if (k6 == {1'b0, i_nrx}) begin
            o_done <= 1'b1;
            o_ok <= i_ok;
            busy_q <= 1'b0;
         end
      end
   end
endmodule

// File: bench/sccmd_handler_tb.sv
`timescale 1ns/1ps
// ====================
// command handler bench
module sccmd_handler_tb;
   reg i_clk = 1'b0;
   reg i_resetn = 1'b0;
   reg cv = 1'b0, cl = 1'b0, enc = 1'b0, rr = 1'b0, m_ok = 1'b1;
   reg [7:0] cd = 8'h00, m_st = 8'h90;
   reg [4:0] m_n = 5'h00;
   reg [3:0] m_w = 4'h0;
   wire rdy, req, des, crc, cenc, done, ok, rxv, rv, rl, pend, known;
   wire [7:0] op, txd, st, rxd, rd;
   wire [5:0] len;
   wire [4:0] idx;
   integer fail_count = 0;
   integer checks = 0;
   integer cyc = 0;
   integer i;
   reg [7:0] sts [0:8] = '{8'h90, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0f};
   reg [7:0] ops [0:7] = '{8'h90, 8'h8e, 8'h8f, 8'h98, 8'h99, 8'h95, 8'h91, 8'h92};
   reg [7:0] fcs [0:7] = '{8'h6f, 8'h71, 8'h70, 8'h67, 8'h67, 8'h6a, 8'h6e, 8'h6d};
   integer lens [0:7] = '{17, 1, 16, 3, 0, 5, 8, 0};
   sccmd_handler dut (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_cmd_valid(cv), .i_cmd_data(cd), .i_cmd_last(cl),
      .o_cmd_ready(rdy), .i_rf_encrypt(enc), .o_card_req(req), .o_card_op(op), .o_card_des(des),
      .o_card_crc(crc), .o_card_encrypt(cenc), .o_card_len(len), .o_card_tx_data(txd), .i_card_tx_idx(idx),
      .i_card_done(done), .i_card_ok(ok), .i_card_status(st), .i_card_rx_valid(rxv), .i_card_rx_data(rxd),
      .o_rsp_valid(rv), .o_rsp_data(rd), .o_rsp_last(rl), .i_rsp_ready(rr), .o_auth_pending(pend),
      .o_status_known(known)
   );
   sccmd_card_model card (
      .i_clk(i_clk), .i_req(req), .i_ok(m_ok), .i_status(m_st), .i_nrx(m_n), .i_wait(m_w),
      .o_tx_idx(idx), .o_done(done), .o_ok(ok), .o_status(st), .o_rx_valid(rxv), .o_rx_data(rxd)
   );
   always #25 i_clk = ~i_clk;
   task finish_test;
      begin
         $display("checks=%0d fail_count=%0d", checks, fail_count);
         if (fail_count == 0 && checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // hang guard, 8000 cycles is ample here
   always @(posedge i_clk) begin
      cyc = cyc + 1;
      if (cyc == 8000) begin
         fail_count = fail_count + 1;
         finish_test;
      end
   end
   task chk(input [15:0] got, input [15:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task send(input [7:0] c, input integer n, input ok_i, input [7:0] s, input [4:0] nrx, input [3:0] w);
      integer k;
      begin
         m_ok = ok_i;
         m_st = s;
         m_n = nrx;
         m_w = w;
         for (k = 0; k <= n; k = k + 1) begin
            @(negedge i_clk);
            while (!rdy) @(negedge i_clk);
            cv = 1'b1;
            cd = (k == 0) ? c : k[7:0];
            cl = (k == n);
         end
         @(negedge i_clk);
         cv = 1'b0;
         cl = 1'b0;
      end
   endtask
   task get(input [7:0] exp, input lst);
      integer w;
      begin
         w = 0;
         @(negedge i_clk);
         while (rv !== 1'b1 && w < 300) begin
            @(negedge i_clk);
            w = w + 1;
         end
         chk({6'h0, rv, rl, rd}, {6'h0, 1'b1, lst, exp});
         rr = 1'b1;
         @(negedge i_clk);
         rr = 1'b0;
      end
   endtask
   task okrep(input [7:0] c, input [7:0] s, input integer n);
      integer k;
      begin
         get(c, 1'b0);
         get(s, n == 0);
         for (k = 0; k < n; k = k + 1)
            get(8'ha0 + k[7:0], k == n - 1);
      end
   endtask
   task t_auth;
      begin
         send(8'h90, 17, 1'b1, 8'h90, 5'd16, 4'd5);
         okrep(8'h90, 8'h90, 16);
         send(8'h90, 17, 1'b1, 8'h06, 5'd16, 4'd0);
         okrep(8'h90, 8'h06, 0);
      end
   endtask
   task t_two_step;
      begin
         send(8'h8e, 1, 1'b1, 8'haf, 5'd8, 4'd0);
         okrep(8'h8e, 8'haf, 8);
         chk({15'h0, pend}, 16'h0001);
         // host keeps cipher and key build; nonce bytes pass raw
         send(8'h8f, 16, 1'b1, 8'h90, 5'd8, 4'd3);
         okrep(8'h8f, 8'h90, 8);
         chk({15'h0, pend}, 16'h0000);
      end
   endtask
   task t_status;
      begin
         for (i = 0; i < 9; i = i + 1) begin
            send(8'h92, 0, 1'b1, sts[i], 5'd2, 4'd0);
            okrep(8'h92, sts[i], 2);
            chk({15'h0, known}, 16'h0001);
         end
         send(8'h92, 0, 1'b1, 8'h55, 5'd2, 4'd0);
         okrep(8'h92, 8'h55, 2);
         chk({15'h0, known}, 16'h0000);
      end
   endtask
   task t_plain_ops;
      begin
         enc = 1'b1;
         send(8'h98, 3, 1'b1, 8'h90, 5'd0, 4'd0);
         okrep(8'h98, 8'h90, 0);
         chk({15'h0, cenc}, 16'h0001);
         chk({10'h0, len}, 16'h0003);
         send(8'h95, 5, 1'b1, 8'h0b, 5'd0, 4'd2);
         okrep(8'h95, 8'h0b, 0);
         send(8'h91, 8, 1'b1, 8'h90, 5'd0, 4'd0);
         okrep(8'h91, 8'h90, 0);
         send(8'h99, 0, 1'b1, 8'h90, 5'd0, 4'd0);
         okrep(8'h99, 8'h90, 0);
      end
   endtask
   task t_fails;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            send(ops[i], lens[i], 1'b0, 8'h90, 5'd0, 4'd1);
            get(fcs[i], 1'b1);
         end
         send(8'h98, 2, 1'b1, 8'h90, 5'd0, 4'd0);
         get(8'h67, 1'b1);
         send(8'h95, 4, 1'b1, 8'h90, 5'd0, 4'd0);
         get(8'h6a, 1'b1);
         send(8'h55, 0, 1'b1, 8'h90, 5'd0, 4'd0);
         get(8'hff, 1'b1);
      end
   endtask
   initial begin
      repeat (5) @(negedge i_clk);
      i_resetn = 1'b1;
      t_auth;
      t_two_step;
      t_status;
      t_plain_ops;
      t_fails;
      finish_test;
   end
endmodule
